/* design/ssgr_top.sv */
// Setpoint group selection and ramp generator with an APB register slave.
// Assumes mode, process value and remote setpoint come from logic on ref_clk;
// contact inputs may come from anywhere and are synchronised here.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module ssgr_top #(
  parameter logic [47:0] SEC_CYCLES = 48'(ssgr_pkg::SEC_CYCLES_DFLT)
) (
  input  wire logic                                ref_clk,
  input  wire logic                                rst_n,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic        [ssgr_pkg::ADDR_W-1:0]   paddr,
  input  wire logic        [ssgr_pkg::DATA_W-1:0]   pwdata,
  output logic             [ssgr_pkg::DATA_W-1:0]   prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic        [ssgr_pkg::CONTACTS-1:0] contact_input,
  input  wire ssgr_pkg::ssgr_mode_t                mode,
  input  wire logic signed [ssgr_pkg::SP_W-1:0]     process_value,
  input  wire logic signed [ssgr_pkg::SP_W-1:0]     remote_setpoint,
  output logic signed      [ssgr_pkg::SP_W-1:0]     working_setpoint,
  output logic             [3:0]                   active_group,
  output logic                                     ramp_active
);

  // Hour divisor must fit the accumulator
  if (SEC_CYCLES < 48'h1 || SEC_CYCLES > 48'h0000_FFFF_FFFF)
  begin : g_bad_sec
    $error("ssgr_top: SEC_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [47:0] DIV_SEC  = SEC_CYCLES * 48'(ssgr_pkg::TENTHS);
  localparam logic [47:0] DIV_MIN  = DIV_SEC * 48'(ssgr_pkg::MINUTE_SECONDS);
  localparam logic [47:0] DIV_HOUR = DIV_SEC * 48'(ssgr_pkg::HOUR_SECONDS);

  ssgr_pkg::ssgr_cfg_t           cfg;
  ssgr_pkg::ssgr_cfg_t           next_cfg;
  ssgr_pkg::ssgr_state_t         state;
  ssgr_pkg::ssgr_state_t         next_state;
  logic [ssgr_pkg::CONTACTS-1:0] contact_meta;
  logic [ssgr_pkg::CONTACTS-1:0] contact_sync;
  logic                          ack;
  logic                          next_ack;
  logic [31:0]                   next_prdata;
  logic                          next_pslverr;
  logic [3:0]                    next_active_group;
  logic signed [15:0]            next_working_sp;
  logic                          next_ramp_active;
  logic [47:0]                   acc;
  logic [47:0]                   next_acc;
  logic [47:0]                   acc_sum;
  logic [47:0]                   divisor;
  logic                          run_q;
  logic                          auto_q;
  logic                          restart;
  logic                          access;
  logic                          wr_commit;
  logic                          mapped;
  logic                          wr_slope;
  logic                          wr_spt;
  logic [13:0]                   slope_rd;
  logic [13:0]                   slope_bus;
  logic [15:0]                   spt_rd;
  logic [15:0]                   spt_bus;
  logic signed [15:0]            target;
  logic [13:0]                   up_rate;
  logic [13:0]                   down_rate;
  logic                          ramp_possible;
  logic [4:0]                    sel_sum;
  logic [4:0]                    grp_raw;
  logic                          any_sel;
  logic [1:0]                    ct;
  logic [2:0]                    grp_idx;

  // ---------------------------------------------------------------
  // Contact synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      contact_meta <= '0;
      contact_sync <= '0;
    end
    else
    begin
      contact_meta <= contact_input;
      contact_sync <= contact_meta;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Two access cycles: the first captures read data into a register
  assign access    = psel && penable;
  assign wr_commit = access && ack && pwrite;
  assign wr_slope  = wr_commit && paddr[7:5] == ssgr_pkg::BLK_SLOPE && paddr[1:0] == 2'h0
                     && pwdata <= ssgr_pkg::RATE_MAX; // R07 R11
  assign wr_spt    = wr_commit && paddr[7:5] == ssgr_pkg::BLK_LOCAL_SP && paddr[1:0] == 2'h0;
  assign grp_idx   = 3'(active_group - 4'h1);

  always_comb
  begin
    next_ack     = access && !ack;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    mapped       = 1'b1;
    next_cfg     = cfg;
    case (paddr)
      ssgr_pkg::OFS_CONTACT_TYPE:  next_prdata = {22'h0, cfg.contact_type}; // R04
      ssgr_pkg::OFS_CONTACT_STATE: next_prdata = {27'h0, contact_sync};
      ssgr_pkg::OFS_GROUP_COUNT:   next_prdata = {28'h0, cfg.group_count};
      ssgr_pkg::OFS_RAMP_STYLE:    next_prdata = {30'h0, cfg.style};
      ssgr_pkg::OFS_TIME_BASE:     next_prdata = {30'h0, cfg.time_base};
      ssgr_pkg::OFS_RISE_RATE:     next_prdata = {18'h0, cfg.rise};
      ssgr_pkg::OFS_FALL_RATE:     next_prdata = {18'h0, cfg.fall};
      ssgr_pkg::OFS_OP_GROUP:      next_prdata = {28'h0, cfg.op_group};
      ssgr_pkg::OFS_STATUS:
        next_prdata = {26'h0, ramp_active, state == ssgr_pkg::ST_REMOTE, active_group};
      ssgr_pkg::OFS_WORKING_SP:    next_prdata = {16'h0, working_setpoint};
      default:
      begin
        if (paddr[1:0] == 2'h0 && paddr[7:5] == ssgr_pkg::BLK_SLOPE)
        begin
          next_prdata = {18'h0, slope_bus};
        end
        else if (paddr[1:0] == 2'h0 && paddr[7:5] == ssgr_pkg::BLK_LOCAL_SP)
        begin
          next_prdata = {16'h0, spt_bus};
        end
        else
        begin
          next_prdata = 32'h0000_0000;
          mapped      = 1'b0;
        end
      end
    endcase
    if (access && !ack)
    begin
      next_pslverr = !mapped;
      if (pwrite)
      begin
        next_prdata = 32'h0000_0000;
      end
    end
    else
    begin
      next_prdata  = prdata;
    end
    // Out-of-range values are dropped, except the contact types and ramp style, which take their low 10 and 2 bits unchecked
    if (wr_commit)
    begin
      case (paddr)
        ssgr_pkg::OFS_CONTACT_TYPE: next_cfg.contact_type = pwdata[9:0]; // R01
        ssgr_pkg::OFS_GROUP_COUNT:
        begin
          if (pwdata >= 32'(ssgr_pkg::GROUP_MIN) && pwdata <= 32'(ssgr_pkg::GROUP_MAX))
          begin
            next_cfg.group_count = pwdata[3:0];
          end
        end
        ssgr_pkg::OFS_RAMP_STYLE: next_cfg.style = pwdata[1:0];
        ssgr_pkg::OFS_TIME_BASE:
        begin
          if (pwdata <= 32'(ssgr_pkg::TB_HOUR))
          begin
            next_cfg.time_base = pwdata[1:0]; // R05
          end
        end
        ssgr_pkg::OFS_RISE_RATE:
        begin
          if (pwdata <= ssgr_pkg::RATE_MAX)
          begin
            next_cfg.rise = pwdata[13:0]; // R07
          end
        end
        ssgr_pkg::OFS_FALL_RATE:
        begin
          if (pwdata <= ssgr_pkg::RATE_MAX)
          begin
            next_cfg.fall = pwdata[13:0]; // R07
          end
        end
        ssgr_pkg::OFS_OP_GROUP:
        begin
          if (pwdata >= 32'(ssgr_pkg::GROUP_MIN) && pwdata <= 32'(ssgr_pkg::GROUP_MAX))
          begin
            next_cfg.op_group = pwdata[3:0];
          end
        end
        default: next_cfg = cfg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Slope and local setpoint stores
  // ---------------------------------------------------------------
  ssgr_word_mem #(
    .WIDTH (ssgr_pkg::RATE_W),
    .DEPTH (ssgr_pkg::GROUPS),
    .AW    (ssgr_pkg::GRP_AW)
  ) u_slope_mem (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .wr_en     (wr_slope),
    .wr_addr   (paddr[4:2]),
    .wr_data   (pwdata[13:0]),
    .rd_addr_a (grp_idx), // R12
    .rd_data_a (slope_rd),
    .rd_addr_b (paddr[4:2]),
    .rd_data_b (slope_bus)
  );

  ssgr_word_mem #(
    .WIDTH (ssgr_pkg::SP_W),
    .DEPTH (ssgr_pkg::GROUPS),
    .AW    (ssgr_pkg::GRP_AW)
  ) u_spt_mem (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .wr_en     (wr_spt),
    .wr_addr   (paddr[4:2]),
    .wr_data   (pwdata[15:0]),
    .rd_addr_a (grp_idx),
    .rd_data_a (spt_rd),
    .rd_addr_b (paddr[4:2]),
    .rd_data_b (spt_bus)
  );

  assign target = $signed(spt_rd);

  // ---------------------------------------------------------------
  // Group selection
  // ---------------------------------------------------------------
  always_comb
  begin
    sel_sum = 5'h00;
    any_sel = 1'b0;
    ct      = ssgr_pkg::CT_NONE;
    for (int i = 0; i < ssgr_pkg::CONTACTS; i++)
    begin
      ct = cfg.contact_type[2*i +: 2];
      if (ct != ssgr_pkg::CT_NONE)
      begin
        any_sel = 1'b1;
      end
      if (contact_sync[i])
      begin
        case (ct) // R01
          ssgr_pkg::CT_WEIGHT1: sel_sum = sel_sum + ssgr_pkg::WEIGHT1;
          ssgr_pkg::CT_WEIGHT2: sel_sum = sel_sum + ssgr_pkg::WEIGHT2;
          ssgr_pkg::CT_WEIGHT4: sel_sum = sel_sum + ssgr_pkg::WEIGHT4;
          default:              sel_sum = sel_sum;
        endcase
      end
    end
    // Without any selecting contact the operator group number applies
    grp_raw = any_sel ? 5'(sel_sum + 5'h01) : {1'b0, cfg.op_group}; // R02
    if (grp_raw > {1'b0, cfg.group_count})
    begin
      grp_raw = {1'b0, cfg.group_count}; // R03
    end
    if (cfg.group_count == ssgr_pkg::GROUP_MIN)
    begin
      grp_raw = {1'b0, ssgr_pkg::GROUP_MIN}; // R04
    end
    next_active_group = grp_raw[3:0];
  end

  // ---------------------------------------------------------------
  // Ramp engine
  // ---------------------------------------------------------------
  always_comb
  begin
    case (cfg.style) // R08 R11
      ssgr_pkg::STYLE_STD:
      begin
        up_rate   = cfg.rise;
        down_rate = cfg.fall;
      end
      ssgr_pkg::STYLE_MULTI:
      begin
        up_rate   = slope_rd;
        down_rate = slope_rd;
      end
      default:
      begin
        up_rate   = 14'h0000;
        down_rate = 14'h0000;
      end
    endcase
    case (cfg.time_base) // R05
      ssgr_pkg::TB_MINUTE: divisor = DIV_MIN;
      ssgr_pkg::TB_HOUR:   divisor = DIV_HOUR;
      default:             divisor = DIV_SEC;
    endcase
  end

  // Simultaneous run and auto rise is not a listed restart
  assign ramp_possible = up_rate != 14'h0000 || down_rate != 14'h0000;
  assign restart = (mode.run && !run_q && mode.auto_mode && auto_q)
                || (mode.auto_mode && !auto_q && mode.run && run_q)
                || mode.autotune_end; // R09

  always_comb
  begin
    next_state       = state;
    next_working_sp  = working_setpoint;
    next_acc         = acc;
    acc_sum          = 48'h0;
    next_ramp_active = 1'b0;
    case (state)
      ssgr_pkg::ST_INIT: next_state = ssgr_pkg::ST_LOAD; // Wait for store read
      ssgr_pkg::ST_LOAD:
      begin
        next_state      = ssgr_pkg::ST_LOCAL;
        next_working_sp = ramp_possible ? process_value : target; // R09
        next_acc        = 48'h0;
      end
      ssgr_pkg::ST_LOCAL:
      begin
        if (mode.remote_sel)
        begin
          next_state      = ssgr_pkg::ST_REMOTE;
          next_working_sp = remote_setpoint; // R10
          next_acc        = 48'h0;
        end
        else if (restart && ramp_possible)
        begin
          next_working_sp = process_value; // R09
          next_acc        = 48'h0;
        end
        else if (target > working_setpoint)
        begin
          acc_sum = acc + 48'(up_rate); // R06
          if (up_rate == 14'h0000)
          begin
            next_working_sp = target; // R07
            next_acc        = 48'h0;
          end
          else if (acc_sum >= divisor)
          begin
            next_working_sp  = 16'(working_setpoint + 16'sh0001); // R14
            next_acc         = acc_sum - divisor;
            next_ramp_active = 1'b1;
          end
          else
          begin
            next_acc         = acc_sum;
            next_ramp_active = 1'b1;
          end
        end
        else if (target < working_setpoint)
        begin
          acc_sum = acc + 48'(down_rate); // R06
          if (down_rate == 14'h0000)
          begin
            next_working_sp = target; // R07
            next_acc        = 48'h0;
          end
          else if (acc_sum >= divisor)
          begin
            next_working_sp  = 16'(working_setpoint - 16'sh0001); // R14
            next_acc         = acc_sum - divisor;
            next_ramp_active = 1'b1;
          end
          else
          begin
            next_acc         = acc_sum;
            next_ramp_active = 1'b1;
          end
        end
        else
        begin
          next_acc = 48'h0;
        end
      end
      ssgr_pkg::ST_REMOTE:
      begin
        next_working_sp = remote_setpoint; // R10
        next_acc        = 48'h0;
        if (!mode.remote_sel)
        begin
          next_state = ssgr_pkg::ST_LOCAL;
        end
      end
      default: next_state = ssgr_pkg::ST_INIT;
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg.contact_type <= ssgr_pkg::RST_CONTACT_TYPE; // R15
      cfg.group_count  <= ssgr_pkg::RST_GROUP_COUNT;
      cfg.style        <= ssgr_pkg::RST_RAMP_STYLE;
      cfg.time_base    <= ssgr_pkg::RST_TIME_BASE; // R15
      cfg.rise         <= ssgr_pkg::RST_RATE; // R15
      cfg.fall         <= ssgr_pkg::RST_RATE; // R15
      cfg.op_group     <= ssgr_pkg::RST_OP_GROUP;
      state            <= ssgr_pkg::ST_INIT;
      ack              <= 1'b0;
      prdata           <= 32'h0000_0000;
      pslverr          <= 1'b0;
      active_group     <= ssgr_pkg::RST_OP_GROUP;
      working_setpoint <= 16'sh0000;
      ramp_active      <= 1'b0;
      acc              <= 48'h0;
      run_q            <= 1'b0;
      auto_q           <= 1'b0;
    end
    else
    begin
      cfg              <= next_cfg;
      state            <= next_state;
      ack              <= next_ack;
      prdata           <= next_prdata;
      pslverr          <= next_pslverr;
      active_group     <= next_active_group;
      working_setpoint <= next_working_sp;
      ramp_active      <= next_ramp_active;
      acc              <= next_acc;
      run_q            <= mode.run;
      auto_q           <= mode.auto_mode;
    end
  end

  assign pready = ack;

endmodule

/* design/ssgr_word_mem.sv */
// Small word memory with one write port and two registered read ports.
// Assumes DEPTH fills the address space and all ports share ref_clk.
`timescale 1ns/1ns
module ssgr_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr_a,
  output logic      [WIDTH-1:0] rd_data_a,
  input  wire logic [AW-1:0]    rd_addr_b,
  output logic      [WIDTH-1:0] rd_data_b
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_rd_a;
  logic [WIDTH-1:0] next_rd_b;

  // Partial depth would let an address read past the array
  if (DEPTH != (1 << AW) || WIDTH < 1)
  begin : g_bad_shape
    $error("ssgr_word_mem: DEPTH must equal 2**AW");
  end

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (wr_en)
    begin
      next_mem[wr_addr] = wr_data;
    end
    next_rd_a = mem[rd_addr_a];
    next_rd_b = mem[rd_addr_b];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0; // R15
      end
      rd_data_a <= '0;
      rd_data_b <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= next_mem[i];
      end
      rd_data_a <= next_rd_a;
      rd_data_b <= next_rd_b;
    end
  end

endmodule

/* include/ssgr_pkg.sv */
// Constants, register map and carriers of the setpoint group select and ramp block.
// Assumes an APB master with 32-bit data and a single 250 MHz ref_clk.
// How it works
// R01: Contact type codes: 0 none, 1 weight one, 2 weight two, 3 weight four.
// R02: Active group is one plus the weights of contacts that are on.
// R03: A group above the configured count is clipped to that count.
// R04: Group count of one disables contact selection; types stay readable.
// R05: Time base code 0 per second, 1 per minute, 2 per hour.
// R06: One rate step is a tenth of one setpoint count.
// R07: Rise and fall accept 0.1 to 999.9; zero disables that direction only.
// R08: Rise and fall rates act only in the standard ramp style.
// R09: Ramp restarts from process value at power-on, run, auto, autotune end.
// R10: Remote setpoint passes straight through without ramping.
// R11: Multi-ramp uses one slope per group for both directions; zero disables.
// R12: Eight slopes are held; slope n serves local group n.
// R13: Operator changes a slope only while no ramp is running; the code accepts slope writes at any time.
// R14: Setpoint steps toward target at the rate and stops exactly on it.
// R15: After reset types, time base, rates and slopes are all zero.
package ssgr_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SP_W     = 16;
  localparam int RATE_W   = 14;
  localparam int GRP_AW   = 3;
  localparam int GROUPS   = 8;
  localparam int CONTACTS = 5;
  localparam int ACC_W    = 48;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTACT_TYPE  = 8'h00;
  localparam logic [7:0] OFS_CONTACT_STATE = 8'h04;
  localparam logic [7:0] OFS_GROUP_COUNT   = 8'h08;
  localparam logic [7:0] OFS_RAMP_STYLE    = 8'h0C;
  localparam logic [7:0] OFS_TIME_BASE     = 8'h10;
  localparam logic [7:0] OFS_RISE_RATE     = 8'h14;
  localparam logic [7:0] OFS_FALL_RATE     = 8'h18;
  localparam logic [7:0] OFS_OP_GROUP      = 8'h1C;
  localparam logic [7:0] OFS_STATUS        = 8'h20;
  localparam logic [7:0] OFS_WORKING_SP    = 8'h24;
  localparam logic [2:0] BLK_SLOPE         = 3'h2;
  localparam logic [2:0] BLK_LOCAL_SP      = 3'h3;

  // ---------------------------------------------------------------
  // Field codes and limits
  // ---------------------------------------------------------------
  localparam logic [1:0]  CT_NONE     = 2'h0;
  localparam logic [1:0]  CT_WEIGHT1  = 2'h1;
  localparam logic [1:0]  CT_WEIGHT2  = 2'h2;
  localparam logic [1:0]  CT_WEIGHT4  = 2'h3;
  localparam logic [4:0]  WEIGHT1     = 5'h01;
  localparam logic [4:0]  WEIGHT2     = 5'h02;
  localparam logic [4:0]  WEIGHT4     = 5'h04;
  localparam logic [1:0]  TB_SECOND   = 2'h0;
  localparam logic [1:0]  TB_MINUTE   = 2'h1;
  localparam logic [1:0]  TB_HOUR     = 2'h2;
  localparam logic [1:0]  STYLE_STD   = 2'h0;
  localparam logic [1:0]  STYLE_MULTI = 2'h1;
  localparam logic [31:0] RATE_MAX    = 32'h0000_270F;
  localparam logic [3:0]  GROUP_MIN   = 4'h1;
  localparam logic [3:0]  GROUP_MAX   = 4'h8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [9:0]  RST_CONTACT_TYPE = 10'h000;
  localparam logic [3:0]  RST_GROUP_COUNT  = 4'h1;
  localparam logic [1:0]  RST_RAMP_STYLE   = 2'h0;
  localparam logic [1:0]  RST_TIME_BASE    = 2'h0;
  localparam logic [13:0] RST_RATE         = 14'h0000;
  localparam logic [3:0]  RST_OP_GROUP     = 4'h1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SECOND_NS       = 1_000_000_000;
  localparam int SEC_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;
  localparam int TENTHS          = 10;
  localparam int MINUTE_SECONDS  = 60;
  localparam int HOUR_SECONDS    = 3600;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic auto_mode;
    logic autotune_end;
    logic remote_sel;
  } ssgr_mode_t;

  typedef struct packed {
    logic [9:0]  contact_type;
    logic [3:0]  group_count;
    logic [1:0]  style;
    logic [1:0]  time_base;
    logic [13:0] rise;
    logic [13:0] fall;
    logic [3:0]  op_group;
  } ssgr_cfg_t;

  typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_LOCAL, ST_REMOTE} ssgr_state_t;

endpackage

/* test/ssgr_asserts.sv */
// Port checker for ssgr_top: bus handshake, group range, ramp steps.
// Assumes one ref_clk domain and rst_n active low.
`timescale 1ns/1ns
module ssgr_asserts (
  input logic                 ref_clk,
  input logic                 rst_n,
  input logic                 psel,
  input logic                 penable,
  input logic [7:0]           paddr,
  input logic                 pready,
  input logic                 pslverr,
  input ssgr_pkg::ssgr_mode_t mode,
  input logic signed [15:0]   remote_setpoint,
  input logic signed [15:0]   working_setpoint,
  input logic [3:0]           active_group,
  input logic                 ramp_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  a_ready_wait: assert property (s_setup |=> s_answer)
    else $error("ready late");
  a_ack_pulse: assert property (pready |=> !pready)
    else $error("ready long");
  a_ack_access: assert property (pready |-> psel && penable)
    else $error("ready idle");
  a_err_unmapped: assert property (pready && paddr[7] |-> pslverr)
    else $error("no error");
  a_group_range: assert property (active_group inside {[4'h1:4'h8]})
    else $error("bad group");
  a_reset_out: assert property (!$past(rst_n) |-> working_setpoint == 16'sh0000
    && active_group == 4'h1 && !ramp_active) else $error("reset out");
  a_remote_pass: assert property ($past(mode.remote_sel) && $past(mode.remote_sel, 2)
    && $past(rst_n, 2) |-> working_setpoint == $past(remote_setpoint)) else $error("remote");
  // Mode edges may restart the ramp at PV, so only stable stretches count
  a_step_limit: assert property (ramp_active && $past(ramp_active) && $stable(mode)
    |-> (working_setpoint - $past(working_setpoint)) inside {16'shFFFF, 16'sh0000, 16'sh0001})
    else $error("step size");
endmodule
bind ssgr_top ssgr_asserts ssgr_asserts_i (.ref_clk, .rst_n, .psel, .penable, .paddr,
  .pready, .pslverr, .mode, .remote_setpoint, .working_setpoint, .active_group, .ramp_active);

/* test/ssgr_op_model.sv */
// Operator stand-in: contact inputs and mode lines.
// Assumes the bench sets its wants just after a rising edge.
`timescale 1ns/1ns
module ssgr_op_model (
  input  wire logic                 ref_clk,
  input  wire logic [4:0]           want_contacts,
  input  wire ssgr_pkg::ssgr_mode_t want_mode,
  output logic [4:0]                contact_input = 5'h00,
  output ssgr_pkg::ssgr_mode_t      mode = '0
);
  // Changes only on the clock, as panel logic would
  always @(posedge ref_clk)
  begin
    contact_input <= want_contacts;
    mode <= want_mode;
  end
endmodule

/* test/test_setpoint_group_select_ramp.sv */
// Bench for ssgr_top: group table, then ramp, restart, remote.
// Assumes ssgr_op_model drives contacts and mode.
`timescale 1ns/1ns
module test_setpoint_group_select_ramp;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ramp_active, err;
  logic [4:0] cin = 5'h00;
  logic [4:0] contact_input;
  ssgr_pkg::ssgr_mode_t md = '0;
  ssgr_pkg::ssgr_mode_t mode;
  logic signed [15:0] pv = 16'sh0000;
  logic signed [15:0] rmt = 16'sh0000;
  logic signed [15:0] sp;
  logic [3:0] grp;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] rz [6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h5C};
  // Contacts beside expected group; types are 1,2,3,0,1
  logic [8:0] rows [8] = '{{5'h00, 4'h1}, {5'h01, 4'h2}, {5'h02, 4'h3}, {5'h04, 4'h5},
    {5'h07, 4'h8}, {5'h08, 4'h1}, {5'h10, 4'h2}, {5'h1F, 4'h8}};
  ssgr_op_model ssgr_op_model_i (.ref_clk, .want_contacts(cin), .want_mode(md),
    .contact_input, .mode);
  // Short second so ramps finish within the run
  ssgr_top #(.SEC_CYCLES(48'h4)) ssgr_top_i (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .contact_input, .mode,
    .process_value(pv), .remote_setpoint(rmt), .working_setpoint(sp),
    .active_group(grp), .ramp_active);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic conclude();
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
    if (++cyc == 6000)
    begin
      chk("timeout", 32'h0, 32'h1);
      conclude();
    end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rz[i])
    begin
      bus(1'b0, rz[i], 32'h0);
      chk("reset reg", 32'h0, rd);
    end
    bus(1'b1, 8'h00, 32'h139);
    bus(1'b1, 8'h08, 32'h8);
    foreach (rows[i])
    begin
      cin <= rows[i][8:4];
      repeat (6) @(posedge ref_clk);
      chk("group", 32'(rows[i][3:0]), 32'(grp));
    end
    bus(1'b1, 8'h08, 32'h3);
    repeat (6) @(posedge ref_clk);
    chk("clip", 32'h3, 32'(grp));
    bus(1'b1, 8'h08, 32'h1);
    repeat (6) @(posedge ref_clk);
    chk("single", 32'h1, 32'(grp));
    bus(1'b0, 8'h00, 32'h0);
    chk("types", 32'h139, rd);
    bus(1'b1, 8'h14, 32'hA);
    bus(1'b1, 8'h60, 32'h14);
    md.auto_mode <= 1'b1;
    @(posedge ref_clk);
    md.run <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("ramping", 32'h1, 32'(ramp_active));
    chk("mid ramp", 32'h1, 32'(sp > 16'sh0002 && sp < 16'sh0007));
    repeat (100) @(posedge ref_clk);
    chk("ramp end", 32'h14, sp);
    bus(1'b1, 8'h60, 32'h5);
    repeat (4) @(posedge ref_clk);
    chk("fall jump", 32'h5, sp);
    bus(1'b1, 8'h10, 32'h1);
    pv <= 16'sh0002;
    md.autotune_end <= 1'b1;
    @(posedge ref_clk);
    md.autotune_end <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("restart", 32'h2, sp);
    repeat (300) @(posedge ref_clk);
    chk("minute", 32'h3, sp);
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h60, 32'hF);
    repeat (4) @(posedge ref_clk);
    chk("multi off", 32'hF, sp);
    bus(1'b1, 8'h40, 32'h28);
    bus(1'b1, 8'h60, 32'h19);
    repeat (4) @(posedge ref_clk);
    chk("multi up", 32'h1, 32'(ramp_active));
    repeat (20) @(posedge ref_clk);
    bus(1'b1, 8'h60, 32'h0);
    repeat (4) @(posedge ref_clk);
    chk("multi down", 32'h1, 32'(ramp_active));
    repeat (30) @(posedge ref_clk);
    rmt <= 16'sh0123;
    md.remote_sel <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("remote", 32'h123, sp);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    conclude();
  end
endmodule
